// ==== hw/bitmr_top.sv ====
// basic 8-bit interval timer with AXI4-Lite register access
//
// What this block does
// RL1: eight-bit counter, one step per selected tick
// RL2: enable bit low holds count, high counts
// RL3: wrap from FF to 00 sets overflow flag
// RL4: overflow flag stays until software clears it
// RL5: no reload; counter continues from zero
// RL6: enabled overflow requests interrupt at vector 000B
// RL7: service routine must clear overflow flag itself
// RL8: counts in all modes; overflow wakes green mode
// RL9: rate codes select instruction clock /256 to /2
// RL10: source select zero uses prescaled instruction clock
// RL11: source select one uses crystal divided by 64
// RL12: crystal mode ignores rate, full half second
// RL13: crystal mode only with crystal clock option
// RL14: mode bits: enable 7, rate 6-4, source 0
// RL15: software configures source and rate before enabling
// RL16: software loads count as 256 minus interval product
// RL17: software loads count before enabling, reloads after
// RL18: software leaves count alone in crystal mode
// RL19: flag sets always; request is flag and enable
`timescale 1ns/1ps
module bitmr_top
  import bitmr_pkg::*;
(
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // timing sources and system state
  input  wire logic              cpu_tick,
  input  wire logic              xtal_in,
  input  wire logic              internal_rc_with_crystal_option,
  input  wire logic              green_mode,
  // write address channel
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // write data channel
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // write response channel
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // read address channel
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // read data channel
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // interrupt and wake-up
  output logic                   irq,
  output logic [15:0]            irq_vector,
  output logic                   wake_up
);

  // ==========================================================
  // declarations
  logic [7:0]        mode_reg;
  logic [7:0]        count_reg;
  logic [7:0]        status_reg;
  logic [7:0]        mask_reg;
  logic              irq_reg;
  logic [15:0]       vector_reg;
  logic              wake_reg;
  bitmr_src_t        src_reg;
  logic              awready_reg;
  logic              wready_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              aw_full_reg;
  logic              w_full_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [31:0]       wdata_reg;
  logic [3:0]        wstrb_reg;
  logic              arready_reg;
  logic              rvalid_reg;
  logic [1:0]        rresp_reg;
  logic [31:0]       rdata_reg;
  logic              rate_tick;
  logic              xtal_tick;
  logic              count_tick;
  logic              overflow;
  logic              do_write;
  logic              wr_lane0;
  logic              wr_mode;
  logic              wr_count;
  logic              wr_status;
  logic              wr_mask;
  logic              timer_enable_bit;
  logic              crystal_source_select;
  logic [RATE_W-1:0] clock_divide_select;

  // register index from a byte address; low two bits are ignored
  function automatic logic [9:0] reg_index(logic [ADDR_W-1:0] addr);
    reg_index = addr[ADDR_W-1:2];
  endfunction

  // true when the index names one of the four registers
  function automatic logic is_mapped(logic [9:0] idx);
    is_mapped = (idx == MODE_INDEX) || (idx == COUNT_INDEX) ||
                (idx == STATUS_INDEX) || (idx == MASK_INDEX);
  endfunction

  // ==========================================================
  // mode fields
  assign timer_enable_bit      = mode_reg[MODE_EN_BIT];
  assign crystal_source_select = mode_reg[MODE_XTAL_BIT];
  assign clock_divide_select   = mode_reg[MODE_RATE_HI:MODE_RATE_LO];

  // ==========================================================
  // clock sources
  bitmr_prescale #(
    .DIV_W (PRESCALE_W)
  ) u_prescale (
    .aclk                (aclk),
    .aresetn             (aresetn),
    .cpu_tick            (cpu_tick),
    .clock_divide_select (clock_divide_select),
    .rate_tick           (rate_tick)
  );

  bitmr_rtc_div #(
    .DIVIDE (RTC_DIVIDE)
  ) u_rtc_div (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .xtal_in   (xtal_in),
    .xtal_tick (xtal_tick)
  );

  // counting source, settles one cycle after a mode or option change
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      src_reg <= SRC_IDLE;
    else if (!timer_enable_bit)
      src_reg <= SRC_IDLE; // RL2
    else if (!crystal_source_select)
      src_reg <= SRC_CPU; // RL10
    else if (internal_rc_with_crystal_option)
      src_reg <= SRC_XTAL; // RL11
    else
      src_reg <= SRC_NONE; // RL13
  end

  // one tick from the selected source; rate ignored in crystal mode
  always_comb
  begin
    count_tick = 1'b0;
    if (timer_enable_bit) // RL2
    begin
      case (src_reg)
        SRC_CPU:  count_tick = rate_tick; // RL10
        SRC_XTAL: count_tick = xtal_tick; // RL11 RL12
        default:  count_tick = 1'b0; // RL13
      endcase
    end
  end

  assign overflow = count_tick && (count_reg == COUNT_FULL); // RL3

  // ==========================================================
  // write bus: address and data are held until both are present
  assign do_write  = aw_full_reg && w_full_reg && !bvalid_reg;
  assign wr_lane0  = do_write && wstrb_reg[0];
  assign wr_mode   = wr_lane0 && (reg_index(awaddr_reg) == MODE_INDEX);
  assign wr_count  = wr_lane0 && (reg_index(awaddr_reg) == COUNT_INDEX);
  assign wr_status = wr_lane0 && (reg_index(awaddr_reg) == STATUS_INDEX);
  assign wr_mask   = wr_lane0 && (reg_index(awaddr_reg) == MASK_INDEX);

  // write address capture
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_reg <= 1'b0;
      awready_reg <= 1'b0;
      awaddr_reg  <= '0;
    end
    else if (s_axi_awvalid && awready_reg)
    begin
      aw_full_reg <= 1'b1;
      awready_reg <= 1'b0;
      awaddr_reg  <= s_axi_awaddr;
    end
    else if (bvalid_reg && s_axi_bready)
      aw_full_reg <= 1'b0;
    else if (!aw_full_reg && !awready_reg)
      awready_reg <= 1'b1;
  end

  // write data capture
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_full_reg <= 1'b0;
      wready_reg <= 1'b0;
      wdata_reg  <= '0;
      wstrb_reg  <= '0;
    end
    else if (s_axi_wvalid && wready_reg)
    begin
      w_full_reg <= 1'b1;
      wready_reg <= 1'b0;
      wdata_reg  <= s_axi_wdata;
      wstrb_reg  <= s_axi_wstrb;
    end
    else if (bvalid_reg && s_axi_bready)
      w_full_reg <= 1'b0;
    else if (!w_full_reg && !wready_reg)
      wready_reg <= 1'b1;
  end

  // write response, error for an unmapped address
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= is_mapped(reg_index(awaddr_reg)) ? RESP_OKAY
                                                    : RESP_SLVERR;
    end
    else if (bvalid_reg && s_axi_bready)
      bvalid_reg <= 1'b0;
  end

  // ==========================================================
  // mode register; unused bits 3..1 stay zero
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mode_reg <= MODE_RESET; // RL14
    else if (wr_mode)
      mode_reg <= wdata_reg[7:0] & MODE_RW_MASK; // RL14
  end

  // counter; a software load wins over a tick in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      count_reg <= COUNT_RESET;
    else if (wr_count)
      count_reg <= wdata_reg[7:0];
    else if (count_tick)
      count_reg <= count_reg + 8'h01; // RL1 RL5
  end

  // overflow flag: sticky, cleared by writing one; a new overflow wins
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      status_reg <= EVENT_RESET;
    else
    begin
      if (wr_status && wdata_reg[OVF_BIT])
        status_reg[OVF_BIT] <= 1'b0; // RL4
      if (overflow)
        status_reg[OVF_BIT] <= 1'b1; // RL3 RL19
    end
  end

  // interrupt enable mask, same layout as the status register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mask_reg <= EVENT_RESET;
    else if (wr_mask)
      mask_reg <= {7'h00, wdata_reg[OVF_BIT]};
  end

  // ==========================================================
  // interrupt request is flag and enable, held as a level
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_reg <= 1'b0;
    else
      irq_reg <= |(status_reg & mask_reg); // RL6 RL19
  end

  // fixed service vector presented with the request
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      vector_reg <= IRQ_VECTOR;
    else
      vector_reg <= IRQ_VECTOR; // RL6
  end

  // wake-up pulse for an overflow seen in green mode
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      wake_reg <= 1'b0;
    else
      wake_reg <= overflow && green_mode; // RL8
  end

  // ==========================================================
  // read bus: one read at a time, answer one edge after address
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= RESP_OKAY;
      rdata_reg   <= '0;
    end
    else if (s_axi_arvalid && arready_reg)
    begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rresp_reg   <= RESP_OKAY;
      case (reg_index(s_axi_araddr))
        MODE_INDEX:   rdata_reg <= {24'h00_0000, mode_reg};
        COUNT_INDEX:  rdata_reg <= {24'h00_0000, count_reg};
        STATUS_INDEX: rdata_reg <= {24'h00_0000, status_reg};
        MASK_INDEX:   rdata_reg <= {24'h00_0000, mask_reg};
        default:
        begin
          rdata_reg <= '0;
          rresp_reg <= RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_reg && s_axi_rready)
    begin
      rvalid_reg  <= 1'b0;
      arready_reg <= 1'b1;
    end
    else if (!rvalid_reg && !arready_reg)
      arready_reg <= 1'b1;
  end

  // ==========================================================
  // outputs, each straight from a flip-flop
  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;
  assign irq           = irq_reg;
  assign irq_vector    = vector_reg;
  assign wake_up       = wake_reg;

endmodule

// ==== hw/bitmr_pkg.sv ====
// constants and types shared by the basic interval timer
package bitmr_pkg;

  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [9:0] MODE_INDEX   = 10'h0_B2;
  localparam logic [9:0] COUNT_INDEX  = 10'h0_B3;
  localparam logic [9:0] STATUS_INDEX = 10'h0_B4;
  localparam logic [9:0] MASK_INDEX   = 10'h0_B5;
  localparam int         ADDR_W       = 12;

  // ==========================================================
  // mode register fields
  localparam int         MODE_EN_BIT   = 7;
  localparam int         MODE_RATE_HI  = 6;
  localparam int         MODE_RATE_LO  = 4;
  localparam int         MODE_XTAL_BIT = 0;
  localparam logic [7:0] MODE_RW_MASK  = 8'hF1;
  localparam logic [7:0] MODE_RESET    = 8'h00;

  // ==========================================================
  // count, status and mask fields
  localparam logic [7:0] COUNT_RESET  = 8'h00;
  localparam logic [7:0] COUNT_FULL   = 8'hFF;
  localparam int         OVF_BIT      = 0;
  localparam logic [7:0] EVENT_RESET  = 8'h00;

  // ==========================================================
  // interrupt vector and clock division
  localparam logic [15:0] IRQ_VECTOR  = 16'h000B;
  localparam int          PRESCALE_W  = 8;
  localparam int          RTC_DIVIDE  = 64;
  localparam int          RATE_W      = 3;

  // ==========================================================
  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // counter source state
  typedef enum logic [1:0]
  {
    SRC_IDLE = 2'b00,
    SRC_CPU  = 2'b01,
    SRC_XTAL = 2'b11,
    SRC_NONE = 2'b10
  } bitmr_src_t;

endpackage

// ==== hw/bitmr_prescale.sv ====
// instruction clock prescaler with eight power-of-two rates
`timescale 1ns/1ps
module bitmr_prescale
  import bitmr_pkg::*;
#(
  parameter int DIV_W = PRESCALE_W
)
(
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // instruction cycle strobe and rate code
  input  wire logic              cpu_tick,
  input  wire logic [RATE_W-1:0] clock_divide_select,
  // one pulse per prescaled period
  output logic                   rate_tick
);

  logic [DIV_W-1:0] div_reg;

  // ones in the low (8 - code) bits: code 0 gives /256, code 7 gives /2
  function automatic logic [DIV_W-1:0] low_mask(logic [RATE_W-1:0] code);
    low_mask = {DIV_W{1'b1}} >> code;
  endfunction

  // free-running divider of the instruction cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      div_reg <= '0;
    else if (cpu_tick)
      div_reg <= div_reg + 1'b1;
  end

  // end of period when every selected low bit is one
  always_comb
  begin
    rate_tick = cpu_tick &&
      ((div_reg & low_mask(clock_divide_select)) ==
       low_mask(clock_divide_select)); // RL9
  end

endmodule

// ==== hw/bitmr_rtc_div.sv ====
// crystal edge detector and divide-by-64 for the half-second mode
`timescale 1ns/1ps
module bitmr_rtc_div
  import bitmr_pkg::*;
#(
  parameter int DIVIDE = RTC_DIVIDE
)
(
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // low-speed crystal level, sampled on aclk
  input  wire logic xtal_in,
  // one pulse per DIVIDE crystal cycles
  output logic      xtal_tick
);

  localparam int CNT_W = $clog2(DIVIDE);

  logic             xtal_prev_reg;
  logic [CNT_W-1:0] xtal_cnt_reg;
  logic             xtal_rise;

  assign xtal_rise = xtal_in && !xtal_prev_reg;

  // remember the last crystal level; starts high so a crystal that is
  // already high when reset lifts does not count as a false edge
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      xtal_prev_reg <= 1'b1;
    else
      xtal_prev_reg <= xtal_in;
  end

  // count crystal rising edges
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      xtal_cnt_reg <= '0;
    else if (xtal_rise)
      xtal_cnt_reg <= xtal_cnt_reg + 1'b1;
  end

  assign xtal_tick = xtal_rise && (xtal_cnt_reg == CNT_W'(DIVIDE - 1)); // RL11

endmodule

// ==== tb/bitmr_top_asserts.sv ====
// port-level assertions for the basic interval timer
`timescale 1ns/1ps
module bitmr_checker
(
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // interrupt and wake-up
  input wire logic        green_mode,
  input wire logic [15:0] irq_vector,
  input wire logic        wake_up
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ==========================================================
  // bus steps
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_b_waiting;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  sequence s_r_waiting;
    s_axi_rvalid && !s_axi_rready;
  endsequence

  // ==========================================================
  // checks
  a_wr_answer:
    assert property (s_wr_taken |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_b_holds:
    assert property (s_b_waiting |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_rd_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_b_done:
    assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer not retired");
  a_r_done:
    assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer not retired");
  a_r_holds:
    assert property (s_r_waiting |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_rd_upper_zero:
    assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_busy_refuse:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("new write taken while busy");
  a_vector_fixed:
    assert property (irq_vector == 16'h000B)
    else $error("wrong vector");
  a_wake_green:
    assert property (wake_up |-> $past(green_mode))
    else $error("wake outside green mode");
  a_wake_pulse:
    assert property (wake_up |=> !wake_up)
    else $error("wake longer than a cycle");
endmodule

bind bitmr_top bitmr_checker i_bitmr_checker (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .green_mode, .irq_vector, .wake_up);

// ==== tb/bitmr_tb.sv ====
// self-checking bench for the basic interval timer
`timescale 1ns/1ps
module bitmr_top_tb
  import bitmr_pkg::*;
;
  localparam logic [ADDR_W-1:0] AM = {MODE_INDEX, 2'b00};
  localparam logic [ADDR_W-1:0] AC = {COUNT_INDEX, 2'b00};
  localparam logic [ADDR_W-1:0] AS = {STATUS_INDEX, 2'b00};
  localparam logic [ADDR_W-1:0] AK = {MASK_INDEX, 2'b00};
  logic              aclk = 0, aresetn = 0, cpu_tick = 0;
  logic              green_mode = 0, xtal_in;
  logic              internal_rc_with_crystal_option = 0;
  logic [2:0]        xc = 0;
  logic [ADDR_W-1:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0]       s_axi_wdata = 0, s_axi_rdata;
  logic [3:0]        s_axi_wstrb = 4'hF;
  logic              s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic              s_axi_bready = 0, s_axi_arvalid = 0;
  logic              s_axi_rready = 0, s_axi_awready, s_axi_wready;
  logic              s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic              irq, wake_up;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic [15:0]       irq_vector;
  int                miscompares = 0, checked = 0, cyc = 0, wakes = 0;

  // clock; crystal level runs eight times slower than aclk
  initial forever #5 aclk = ~aclk;
  assign xtal_in = xc[2];

  // instruction strobe every other cycle, cycle and wake counters
  always @(posedge aclk)
  begin
    cpu_tick <= !cpu_tick;
    xc <= xc + 3'd1;
    cyc <= cyc + 1;
    if (wake_up === 1'b1) wakes <= wakes + 1;
  end

  bitmr_top i_bitmr_top (.aclk, .aresetn, .cpu_tick, .xtal_in,
    .internal_rc_with_crystal_option, .green_mode, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq,
    .irq_vector, .wake_up);

  // ==========================================================
  // helpers
  task automatic test_done;
    $display("compares %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH %0t got %h expected %h", $time, g, e);
    end
  endtask

  // bus write: address and data offered together, each dropped when taken
  // bready stands from the start until the answer is sampled
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do
    begin
      @(posedge aclk);
      if (!aw_done && s_axi_awready === 1'b1)
      begin
        aw_done = 1'b1;
        s_axi_awvalid <= 0;
      end
      if (!w_done && s_axi_wready === 1'b1)
      begin
        w_done = 1'b1;
        s_axi_wvalid <= 0;
      end
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic ar_done;
    ar_done = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do
    begin
      @(posedge aclk);
      if (!ar_done && s_axi_arready === 1'b1)
      begin
        ar_done = 1'b1;
        s_axi_arvalid <= 0;
      end
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
    @(posedge aclk);
  endtask

  task automatic rw(input logic [11:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk(r, RESP_OKAY);
  endtask

  task automatic rr(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, e);
    chk(r, RESP_OKAY);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset_map;
    logic [31:0] d;
    logic [1:0] r;
    rr(AM, 8'h00);
    rr(AC, 8'h00);
    rr(AS, 8'h00);
    rr(AK, 8'h00);
    rd(12'h000, d, r);
    chk(r, RESP_SLVERR);
    chk(d, 8'h00);
    wr(12'h004, 8'hFF, r);
    chk(r, RESP_SLVERR);
    rw(AM, 8'h7F);
    rr(AM, 8'h71);
    rw(AC, 8'h10);
    repeat (600) @(posedge aclk);
    rr(AC, 8'h10);
    // a write with lane 0 off is answered but changes nothing
    s_axi_wstrb <= 4'h0;
    rw(AC, 8'h55);
    rr(AC, 8'h10);
    s_axi_wstrb <= 4'hF;
    rw(AM, 8'h00);
  endtask

  // two reads exactly four tick periods apart differ by four
  task automatic t_rates;
    logic [31:0] c1, c2;
    logic [1:0] r;
    int p, t;
    for (int n = 0; n < 8; n++)
    begin
      p = (256 >> n) * 2;
      rw(AM, {24'h0, 1'b0, n[2:0], 4'h0});
      rw(AC, 8'h00);
      rw(AM, {24'h0, 1'b1, n[2:0], 4'h0});
      t = cyc;
      rd(AC, c1, r);
      while (cyc < t + 4 * p) @(posedge aclk);
      rd(AC, c2, r);
      chk((c2 - c1) & 32'hFF, 4);
    end
    rw(AM, 8'h00);
  endtask

  task automatic t_overflow;
    logic [31:0] c;
    logic [1:0] r;
    int i;
    green_mode <= 1;
    rw(AK, 8'h01);
    rw(AC, 8'hFE);
    rw(AM, 8'hF0);
    i = 0;
    while (irq !== 1'b1 && i < 200)
    begin
      @(posedge aclk);
      i++;
    end
    chk(irq, 1);
    chk(irq_vector, 16'h000B);
    rd(AC, c, r);
    chk(c < 3, 1);
    rr(AS, 8'h01);
    chk(wakes, 1);
    rw(AM, 8'h00);
    repeat (50) @(posedge aclk);
    rr(AS, 8'h01);
    rw(AK, 8'h00);
    chk(irq, 0);
    rw(AS, 8'h01);
    rr(AS, 8'h00);
    green_mode <= 0;
    rw(AC, 8'hFE);
    rw(AM, 8'hF0);
    repeat (40) @(posedge aclk);
    rw(AM, 8'h00);
    rr(AS, 8'h01);
    chk(irq, 0);
    chk(wakes, 1);
    rw(AS, 8'h01);
  endtask

  // crystal source: dead without the option, rate ignored with it
  task automatic t_crystal;
    logic [31:0] c;
    logic [1:0] r;
    rw(AM, 8'h71);
    rw(AC, 8'hFE);
    rw(AM, 8'hF1);
    repeat (1200) @(posedge aclk);
    rr(AC, 8'hFE);
    internal_rc_with_crystal_option <= 1;
    repeat (1100) @(posedge aclk);
    rr(AS, 8'h01);
    rd(AC, c, r);
    chk(c < 2, 1);
    rw(AM, 8'h00);
    rw(AS, 8'h01);
    rr(AS, 8'h00);
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    t_reset_map();
    t_rates();
    t_overflow();
    t_crystal();
    test_done();
  end

  initial
  begin
    #1_000_000;
    miscompares++;
    test_done();
  end
endmodule
